// ===== dv/dpr_ctrl_tb.sv
// Self-checking bench for the dual-port RAM control block
`default_nettype none
module dpr_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] BASE = 32'h0030_0000;
   localparam logic [31:0] CSR = 32'h0000_0A40;
   localparam logic [5:0] AMD = 6'h09;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic jmp = 1'b1;
   logic big = 1'b0;
   logic go = 1'b0;
   logic [5:0] sb_am = 6'h00;
   dpr_pkg::dpr_req_t sb_in = '0;
   dpr_pkg::dpr_req_t cmd = '0;
   dpr_pkg::dpr_req_t pb_in;
   logic system_ack_n, system_bus_fault_n, memory_ack_n, cacheable_indication_n;
   logic private_bus_fault_n;
   logic [31:0] sb_rdata, pb_rdata, r, q, c;
   int err_count = 0;
   int num_checks = 0;
   always #50 sys_clk = ~sys_clk;
   dpr_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .base_switch(12'h003),
      .csr_switch(16'h0A40), .large_array(big), .fault_jumper_en(jmp), .sb_am(sb_am),
      .sb_in(sb_in), .pb_in(pb_in), .system_ack_n(system_ack_n),
      .system_bus_fault_n(system_bus_fault_n), .sb_rdata(sb_rdata),
      .memory_ack_n(memory_ack_n), .cacheable_indication_n(cacheable_indication_n),
      .private_bus_fault_n(private_bus_fault_n), .pb_rdata(pb_rdata));
   dpr_pmodel u_pm (.sys_clk(sys_clk), .go(go), .cmd(cmd), .memory_ack_n(memory_ack_n),
      .private_bus_fault_n(private_bus_fault_n), .pb_in(pb_in));
   // ********************
   // Bus tasks
   // ********************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Answer code in r: 0 none, 1 acknowledge, 2 bus error
   task automatic acc(input logic w, input logic [5:0] am, input logic [31:0] a,
         input logic [31:0] d, input logic [31:0] e);
      @(posedge sys_clk);
      sb_in <= '{1'b1, w, a, d, 4'hF};
      sb_am <= am;
      r = 32'h0;
      for (int i = 0; i < 6 && r == 32'h0; i++) begin
         @(posedge sys_clk);
         #1;
         if (system_ack_n === 1'b0) r = 32'h1;
         else if (system_bus_fault_n === 1'b0) r = 32'h2;
      end
      q = sb_rdata;
      @(posedge sys_clk);
      sb_in.req <= 1'b0;
      @(posedge sys_clk);
      chk("answer", r, e);
   endtask
   task automatic wr(input logic [7:0] v);
      acc(1'b1, dpr_pkg::AM_SHORT_SIO, CSR, {24'h0, v}, 32'h1);
   endtask
   task automatic rd(input logic [7:0] e);
      acc(1'b0, dpr_pkg::AM_SHORT_SIO, CSR, 32'h0, 32'h1);
      chk("control register", q, {24'h0, e});
   endtask
   task automatic pb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      cmd <= '{1'b1, w, a, d, 4'hF};
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      r = 32'h0;
      for (int i = 0; i < 6 && r == 32'h0; i++) begin
         @(posedge sys_clk);
         #1;
         if (memory_ack_n === 1'b0) r = 32'h1;
         else if (private_bus_fault_n === 1'b0) r = 32'h2;
      end
      c = {31'h0, cacheable_indication_n};
      q = pb_rdata;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h00);
      wr(8'hA5);
      rd(8'hA5);
      wr(8'h25);
      rd(8'h25);
      wr(8'h00);
      acc(1'b1, AMD, BASE + 32'h0A40, 32'h0000_00FF, 32'h1);
      rd(8'h00);
      acc(1'b0, dpr_pkg::AM_SHORT_SIO, CSR + 32'h1, 32'h0, 32'h0);
      $display("test register done");
      acc(1'b1, AMD, BASE + 32'h4, 32'h1234_5678, 32'h1);
      acc(1'b0, AMD, BASE + 32'h4, 32'h0, 32'h1);
      chk("array data", q, 32'h1234_5678);
      acc(1'b0, AMD, BASE + 32'h0010_0000, 32'h0, 32'h0);
      acc(1'b0, AMD, BASE - 32'h4, 32'h0, 32'h0);
      for (int f = 0; f < 4; f++) begin
         wr({2'b00, f[1:0], 4'h8});
         for (int s = 0; s < 4; s++) begin
            acc(1'b0, AMD, BASE + (3 - s) * 32'h4_0000, 32'h0, (s >= f) ? 32'h1 : 32'h2);
         end
      end
      big <= 1'b1;
      wr(8'h18);
      acc(1'b0, AMD, BASE + 32'h0030_0000, 32'h0, 32'h2);
      acc(1'b0, AMD, BASE + 32'h0020_0000, 32'h0, 32'h1);
      big <= 1'b0;
      $display("test map done");
      wr(8'h4C);
      acc(1'b0, AMD, BASE + 32'h8, 32'h0, 32'h2);
      pb(1'b1, BASE + 32'hC_0010, 32'hCAFE_F00D);
      chk("private answer", r, 32'h1);
      pb(1'b0, BASE + 32'hC_0010, 32'h0);
      chk("private data", q, 32'hCAFE_F00D);
      chk("cacheable", c, 32'h0);
      wr(8'h40);
      acc(1'b0, AMD, BASE + 32'h8, 32'h0, 32'h0);
      pb(1'b0, BASE + 32'hC_0010, 32'h0);
      chk("not cacheable", c, 32'h1);
      $display("test private done");
      wr(8'h03);
      acc(1'b1, AMD, BASE + 32'h20, 32'h0F0F_0F0F, 32'h1);
      wr(8'h01);
      acc(1'b0, AMD, BASE + 32'h20, 32'h0, 32'h2);
      rd(8'h81);
      pb(1'b0, BASE + 32'h20, 32'h0);
      chk("private fault", r, 32'h2);
      wr(8'h00);
      acc(1'b0, AMD, BASE + 32'h20, 32'h0, 32'h1);
      rd(8'h00);
      jmp <= 1'b0;
      wr(8'h01);
      acc(1'b0, AMD, BASE + 32'h20, 32'h0, 32'h1);
      wr(8'h48);
      acc(1'b0, AMD, BASE + 32'h8, 32'h0, 32'h0);
      $display("test parity done");
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h00);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire

// ===== dv/dpr_pmodel.sv
// Private bus master model: one transfer per go pulse
`default_nettype none
module dpr_pmodel (
   input wire logic sys_clk,
   input wire logic go,
   input wire dpr_pkg::dpr_req_t cmd,
   input wire logic memory_ack_n,
   input wire logic private_bus_fault_n,
   output var dpr_pkg::dpr_req_t pb_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pb_in = '0;
   always @(posedge sys_clk) begin
      if (go) begin
         pb_in <= cmd;
      end else if (!memory_ack_n || !private_bus_fault_n) begin
         // Released lines show inverted values
         pb_in <= {1'b0, ~cmd[68:0]};
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dpr_ctrl.sv
// Control, mapping and parity logic of the dual-port RAM module
`default_nettype none
module dpr_ctrl #(
   parameter int ARRAY_AW = 10
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [11:0] base_switch,
   input wire logic [15:0] csr_switch,
   input wire logic large_array,
   input wire logic fault_jumper_en,
   input wire logic [5:0] sb_am,
   input wire dpr_pkg::dpr_req_t sb_in,
   input wire dpr_pkg::dpr_req_t pb_in,
   output logic system_ack_n,
   output logic system_bus_fault_n,
   output logic [31:0] sb_rdata,
   output logic memory_ack_n,
   output logic cacheable_indication_n,
   output logic private_bus_fault_n,
   output logic [31:0] pb_rdata
);
   // ********************
   // State
   // ********************
   dpr_pkg::dpr_state_t st_reg;
   dpr_pkg::dpr_state_t st_next;
   logic [35:0] mem [2**ARRAY_AW];
   logic [11:0] size_mb;
   logic [11:0] sb_hi;
   logic [11:0] pb_hi;
   logic sb_in_range;
   logic pb_in_range;
   logic [1:0] quarter;
   logic [1:0] seg_num;
   logic blocked;
   logic csr_hit;
   logic pb_go;
   logic sb_go;
   logic sb_arr;
   dpr_pkg::dpr_req_t cur;
   logic [ARRAY_AW-1:0] idx;
   logic [35:0] rd_word;
   logic [3:0] wr_par;
   logic perr;
   logic report;
   logic do_write;
   logic par_event;

   // ********************
   // Address decode
   // ********************
   always_comb begin
      size_mb = large_array ? dpr_pkg::SIZE_LARGE_MB : dpr_pkg::SIZE_SMALL_MB;
      sb_hi = sb_in.addr[31:20] - base_switch;
      pb_hi = pb_in.addr[31:20] - base_switch;
      sb_in_range = (sb_in.addr[31:20] >= base_switch) && (sb_hi < size_mb);
      pb_in_range = (pb_in.addr[31:20] >= base_switch) && (pb_hi < size_mb);
      quarter = large_array ? sb_hi[1:0] : sb_in.addr[19:18];
      seg_num = dpr_pkg::TOP_SEG - quarter;
      blocked = st_reg.csr[dpr_pkg::BIT_WAP]
         || (seg_num < st_reg.csr[dpr_pkg::BIT_PSZ_HI:dpr_pkg::BIT_PSZ_LO]);
   end

   // ********************
   // Port selection
   // ********************
   always_comb begin
      csr_hit = (sb_am == dpr_pkg::AM_SHORT_SIO)
         && (sb_in.addr[15:0] == csr_switch);
      pb_go = pb_in.req && !st_reg.pb_hold && pb_in_range;
      sb_go = sb_in.req && !st_reg.sb_hold && !pb_go;
      sb_arr = sb_go && !csr_hit && (sb_am != dpr_pkg::AM_SHORT_SIO) && sb_in_range;
      cur = pb_go ? pb_in : sb_in;
      if (pb_go) begin
         idx = ARRAY_AW'({pb_hi[1:0], pb_in.addr[19:2]});
      end else begin
         idx = ARRAY_AW'({sb_hi[1:0], sb_in.addr[19:2]});
      end
      do_write = cur.write && (pb_go || (sb_arr && !blocked));
      rd_word = mem[idx];
      report = st_reg.csr[dpr_pkg::BIT_REPORT];
      par_event = (pb_go || (sb_arr && !blocked)) && perr && report;
   end

   // ********************
   // Parity
   // ********************
   always_comb begin
      perr = 1'b0;
      for (int b = 0; b < dpr_pkg::BYTES; b++) begin
         wr_par[b] = (^cur.wdata[8*b +: 8]) ^ st_reg.csr[dpr_pkg::BIT_BADPAR];
         if (cur.be[b] && ((^rd_word[8*b +: 8]) != rd_word[32+b])) begin
            perr = !cur.write;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (do_write) begin
         for (int b = 0; b < dpr_pkg::BYTES; b++) begin
            if (cur.be[b]) begin
               mem[idx][8*b +: 8] <= cur.wdata[8*b +: 8];
               mem[idx][32+b] <= wr_par[b];
            end
         end
      end
   end

   // ********************
   // Next state
   // ********************
   always_comb begin
      st_next = st_reg;
      st_next.sys_ack_n = 1'b1;
      st_next.sys_fault_n = 1'b1;
      st_next.mem_ack_n = 1'b1;
      st_next.cache_n = 1'b1;
      st_next.pb_fault_n = 1'b1;
      if (!sb_in.req) begin
         st_next.sb_hold = 1'b0;
      end
      if (!pb_in.req) begin
         st_next.pb_hold = 1'b0;
      end
      if (sb_go && csr_hit) begin
         st_next.sb_hold = 1'b1;
         st_next.sys_ack_n = 1'b0;
         st_next.sb_rdata = {24'h000000, st_reg.csr};
         if (sb_in.write) begin
            st_next.csr = sb_in.wdata[7:0];
         end
      end else if (sb_arr) begin
         st_next.sb_hold = 1'b1;
         if (blocked) begin
            st_next.sys_fault_n = !(st_reg.csr[dpr_pkg::BIT_PVF] && fault_jumper_en);
         end else if (perr && report && fault_jumper_en) begin
            st_next.sys_fault_n = 1'b0;
         end else begin
            st_next.sys_ack_n = 1'b0;
            st_next.sb_rdata = rd_word[31:0];
         end
      end else if (sb_go) begin
         st_next.sb_hold = 1'b1;
      end
      if (pb_go) begin
         st_next.pb_hold = 1'b1;
         if (perr && report && fault_jumper_en) begin
            st_next.pb_fault_n = 1'b0;
         end else begin
            st_next.mem_ack_n = 1'b0;
            st_next.cache_n = !st_reg.csr[dpr_pkg::BIT_CACHE];
            st_next.pb_rdata = rd_word[31:0];
         end
      end
      if (par_event) begin
         st_next.csr[dpr_pkg::BIT_PE] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{csr: dpr_pkg::CSR_RESET, sb_hold: 1'b0, pb_hold: 1'b0,
                     sys_ack_n: 1'b1, sys_fault_n: 1'b1, sb_rdata: 32'h00000000,
                     mem_ack_n: 1'b1, cache_n: 1'b1, pb_fault_n: 1'b1,
                     pb_rdata: 32'h00000000};
      end else begin
         st_reg <= st_next;
      end
   end

   // ********************
   // Outputs
   // ********************
   always_comb begin
      system_ack_n = st_reg.sys_ack_n;
      system_bus_fault_n = st_reg.sys_fault_n;
      sb_rdata = st_reg.sb_rdata;
      memory_ack_n = st_reg.mem_ack_n;
      cacheable_indication_n = st_reg.cache_n;
      private_bus_fault_n = st_reg.pb_fault_n;
      pb_rdata = st_reg.pb_rdata;
   end

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_csr_write;
      sb_go && csr_hit && sb_in.write;
   endsequence
   sequence s_sb_array;
      sb_arr;
   endsequence
   sequence s_csr_read;
      sb_go && csr_hit && !sb_in.write;
   endsequence
   sequence s_sb_open;
      sb_arr && !blocked;
   endsequence
   sequence s_pb_take;
      pb_go;
   endsequence

   a_csr_write_back: assert property (s_csr_write
      |=> st_reg.csr[6:0] == $past(sb_in.wdata[6:0]))
      else $error("control register write lost");
   a_csr_read_data: assert property (s_csr_read
      |=> !system_ack_n && sb_rdata == {24'h000000, $past(st_reg.csr)})
      else $error("control register readback wrong");
   a_pe_write: assert property (s_csr_write and !(pb_go && perr && report)
      |=> st_reg.csr[7] == $past(sb_in.wdata[7]))
      else $error("parity flag not written");
   a_whole_private: assert property (s_sb_array and st_reg.csr[6]
      |=> system_ack_n)
      else $error("private array acknowledged to system bus");
   a_seg_open: assert property (s_sb_array and !blocked and !perr
      |=> !system_ack_n)
      else $error("open segment not acknowledged");
   a_violation_fault: assert property (s_sb_array and blocked and st_reg.csr[3]
      and fault_jumper_en |=> !system_bus_fault_n ##1 system_bus_fault_n)
      else $error("private violation without bus error");
   a_cache_timing: assert property (!cacheable_indication_n |-> !memory_ack_n)
      else $error("cacheable without acknowledge");
   a_jumper_gate: assert property (!fault_jumper_en
      |=> system_bus_fault_n && private_bus_fault_n)
      else $error("bus error while jumper off");
   a_report_gate: assert property (!report && !(sb_go && csr_hit && sb_in.write)
      |=> !$rose(st_reg.csr[7]))
      else $error("parity flag set while reporting off");
   a_private_open: assert property (pb_go && !(perr && report)
      |=> !memory_ack_n)
      else $error("private access not acknowledged");
   a_out_range: assert property (sb_go && !csr_hit && !sb_in_range
      |=> system_ack_n && system_bus_fault_n)
      else $error("answer outside array");
   a_sb_parity_fault: assert property (s_sb_open and perr and report
      and fault_jumper_en |=> !system_bus_fault_n && system_ack_n)
      else $error("system parity error not signalled");
   a_pb_parity_fault: assert property (s_pb_take and perr and report
      and fault_jumper_en |=> !private_bus_fault_n && memory_ack_n)
      else $error("private parity error not signalled");
   a_parity_flag: assert property (par_event |=> st_reg.csr[dpr_pkg::BIT_PE])
      else $error("parity flag not set");
   a_report_off_ack: assert property (s_sb_open and !report
      |=> !system_ack_n)
      else $error("read refused while reporting off");
   a_jumper_off_ack: assert property (s_sb_open and !fault_jumper_en
      |=> !system_ack_n)
      else $error("read refused while jumper off");
   a_cache_follow: assert property (s_pb_take and st_reg.csr[dpr_pkg::BIT_CACHE]
      and !(perr && report && fault_jumper_en) |=> !cacheable_indication_n)
      else $error("cacheable indication missing");
   a_cache_off: assert property (!st_reg.csr[dpr_pkg::BIT_CACHE]
      |=> cacheable_indication_n)
      else $error("cacheable indication while disabled");
   a_pb_answer: assert property (s_pb_take
      |=> memory_ack_n != private_bus_fault_n)
      else $error("private access without single answer");
   a_pb_one_answer: assert property (!memory_ack_n
      |=> memory_ack_n)
      else $error("private acknowledge repeated");
   a_sb_one_answer: assert property (!system_ack_n
      |=> system_ack_n)
      else $error("system acknowledge repeated");
   a_blocked_no_ack: assert property (s_sb_array and blocked
      |=> system_ack_n)
      else $error("private segment acknowledged");
   a_fault_needs_en: assert property (s_sb_array and blocked
      and !st_reg.csr[dpr_pkg::BIT_PVF] |=> system_bus_fault_n)
      else $error("violation fault while disabled");
   a_low_seg_open: assert property (s_sb_array and !st_reg.csr[dpr_pkg::BIT_WAP]
      and quarter == 2'h0 |=> !system_ack_n || !system_bus_fault_n)
      else $error("lowest segment not answered");
   a_top_seg_private: assert property (s_sb_array and quarter == 2'h3
      and st_reg.csr[dpr_pkg::BIT_PSZ_HI:dpr_pkg::BIT_PSZ_LO] != 2'h0 |=> system_ack_n)
      else $error("highest segment not private");
   a_array_write_ack: assert property (s_sb_open and sb_in.write
      |=> !system_ack_n)
      else $error("array write not acknowledged");
   a_array_keeps_csr: assert property (s_sb_array and sb_in.write
      |=> $stable(st_reg.csr[6:0]))
      else $error("array access changed control register");
   a_io_other_addr: assert property (sb_go and !csr_hit
      and sb_am == dpr_pkg::AM_SHORT_SIO |=> system_ack_n && system_bus_fault_n)
      else $error("answer at unused I/O address");
endmodule
`default_nettype wire

// ===== rtl/dpr_pkg.sv
// Package: constants and carrier types for the dual-port RAM control block
`default_nettype none
package dpr_pkg;
   // ********************
   // Control register bits
   // ********************
   localparam int unsigned BIT_PE = 7;
   localparam int unsigned BIT_WAP = 6;
   localparam int unsigned BIT_PSZ_HI = 5;
   localparam int unsigned BIT_PSZ_LO = 4;
   localparam int unsigned BIT_PVF = 3;
   localparam int unsigned BIT_CACHE = 2;
   localparam int unsigned BIT_BADPAR = 1;
   localparam int unsigned BIT_REPORT = 0;
   localparam logic [7:0] CSR_RESET = 8'h00;
   // ********************
   // Decoding and map
   // ********************
   localparam logic [5:0] AM_SHORT_SIO = 6'h15;
   localparam int unsigned BASE_SHIFT = 20;
   localparam logic [11:0] SIZE_SMALL_MB = 12'h001;
   localparam logic [11:0] SIZE_LARGE_MB = 12'h004;
   localparam logic [1:0] TOP_SEG = 2'h3;
   localparam int unsigned BYTES = 4;
   // ********************
   // Carriers
   // ********************
   typedef struct packed {
      logic req;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } dpr_req_t;
   typedef struct packed {
      logic [7:0] csr;
      logic sb_hold;
      logic pb_hold;
      logic sys_ack_n;
      logic sys_fault_n;
      logic [31:0] sb_rdata;
      logic mem_ack_n;
      logic cache_n;
      logic pb_fault_n;
      logic [31:0] pb_rdata;
   } dpr_state_t;
endpackage
`default_nettype wire
